// [stbr_pkg.sv]
// Package with command codes, block sizes and field positions for the status block reads.
package stbr_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] STBR_CMD_TELEMETRY_BLOCK = 8'hDA;
    localparam logic [7:0] STBR_CMD_STATUS_BLOCK = 8'hDB;
    localparam logic [7:0] STBR_CMD_PHASE_SUMMARY = 8'hDC;

    // ------------------------------------------------------------
    // Block lengths in data bytes
    // ------------------------------------------------------------
    localparam logic [3:0] STBR_TELEMETRY_BYTES = 4'hE;
    localparam logic [3:0] STBR_STATUS_BYTES = 4'h7;
    localparam logic [3:0] STBR_PHASE_BYTES = 4'h2;
    localparam int STBR_MAX_BYTES = 15;

    // ------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------
    localparam int STBR_STATUS_BYTE_CML_BIT = 1;
    localparam int STBR_CML_IVC_BIT = 7;
    localparam logic [7:0] STBR_PHASE_ALL = 8'hFF;
    localparam logic [15:0] STBR_SLOT_UNSUPPORTED = 16'h0000;
    localparam logic [15:0] STBR_SLOT_DISABLED = 16'h0000;
    localparam logic [3:0] STBR_PHASE_FLAGS_RESET = 4'h0;

endpackage : stbr_pkg

// [stbr_byte_serializer.sv]
// Byte serializer that presents a loaded response one byte at a time, low byte first.
`timescale 1ns/10ps
`default_nettype none

module stbr_byte_serializer #(
    parameter int MAX_BYTES = 15
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic load,
    input wire logic [3:0] load_len,
    input wire logic [MAX_BYTES*8-1:0] load_data,
    input wire logic next,
    output logic valid_q,
    output logic [7:0] byte_q,
    output logic last_q
);

    typedef struct packed {
        logic [MAX_BYTES*8-1:0] data;
        logic [3:0] remaining;
        logic valid;
        logic [7:0] cur;
        logic last;
    } stbr_ser_state_t;

    stbr_ser_state_t s_q;
    stbr_ser_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (load) begin
            // A new load, from a read of one of the three commands, aborts any byte stream left unread.
            s_d.cur = load_data[7:0];
            s_d.data = load_data >> 8;
            s_d.remaining = load_len - 4'h1;
            s_d.valid = (load_len != 4'h0);
            s_d.last = (load_len == 4'h1);
        end else if (next && s_q.valid) begin
            if (s_q.remaining == 4'h0) begin
                s_d.valid = 1'b0;
                s_d.last = 1'b0;
            end else begin
                s_d.cur = s_q.data[7:0];
                s_d.data = s_q.data >> 8;
                s_d.remaining = s_q.remaining - 4'h1;
                s_d.last = (s_q.remaining == 4'h1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign valid_q = s_q.valid;
    assign byte_q = s_q.cur;
    assign last_q = s_q.last;

endmodule : stbr_byte_serializer

`default_nettype wire

// [stbr_top.sv]
// Read-side command logic for combined telemetry, combined status and phase summary reads.
// How it works
// - Combined telemetry command answers only as a 14-byte block read.
// - Duty cycle and input current slots always return zero.
// - Input voltage, die temperature, output current sit at 79:64, 63:48, 47:32.
// - Output voltage sits at 31:16, status word at 15:0.
// - A telemetry quantity disabled by configuration reads zero in its slot.
// - Writing a read-only command sets the status byte and communication bit 7 flags.
// - An invalid-command fault asserts the alert line to notify the host.
// - Combined status command is a read-only 7-byte block read.
// - Status block orders manufacturer, other, comms, temperature, input, current, voltage.
// - Writing the combined status command never clears any status bit.
// - Phase summary uses word write and word read and depends on phase.
// - With phase selector FFh the summary shows which phases have faulted.
// - Otherwise bit 0 shows whether the selected phase reports any status.
// - Bits of unassigned or disabled phases always read zero.
// - Summary bits 15:4 read zero; bits 3:0 flag phases 3 to 0, reset 0.
`timescale 1ns/10ps
`default_nettype none

module stbr_top
    import stbr_pkg::*;
#(
    parameter int NUM_PHASES = 4
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_wdata,
    input wire logic rd_next,
    input wire logic cml_clear,
    input wire logic [15:0] status_word,
    input wire logic [7:0] status_mfr,
    input wire logic [7:0] status_other,
    input wire logic [7:0] status_cml,
    input wire logic [7:0] status_temperature,
    input wire logic [7:0] status_input,
    input wire logic [7:0] status_iout,
    input wire logic [7:0] status_vout,
    input wire logic [15:0] telemetry_vin,
    input wire logic [15:0] telemetry_temperature,
    input wire logic [15:0] telemetry_iout,
    input wire logic [15:0] telemetry_vout,
    input wire logic vin_disabled,
    input wire logic iout_disabled,
    input wire logic vout_disabled,
    input wire logic [7:0] phase_select,
    input wire logic [NUM_PHASES-1:0] phase_enabled,
    input wire logic [NUM_PHASES-1:0] phase_fault_event,
    input wire logic selected_phase_status_any,
    output logic rd_valid_q,
    output logic [7:0] rd_byte_q,
    output logic rd_last_q,
    output logic cml_ivc_q,
    output logic alert_n_q,
    output logic [NUM_PHASES-1:0] phase_fault_flags_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ivc;
        logic alert_n;
        logic [NUM_PHASES-1:0] phase_flags;
    } stbr_state_t;

    stbr_state_t s_q;
    stbr_state_t s_d;

    logic [7:0] cml_byte;
    logic [15:0] word_out;
    logic [111:0] telemetry_block;
    logic [55:0] status_block;
    logic [15:0] phase_word;
    logic [NUM_PHASES-1:0] phase_visible;
    logic load;
    logic [3:0] load_len;
    logic [STBR_MAX_BYTES*8-1:0] load_data;
    logic write_read_only;
    logic write_phase;

    // ------------------------------------------------------------
    // Response contents
    // ------------------------------------------------------------
    // The latched invalid-command flag is merged into the status it
    // belongs to, so every path that reports status shows it alike.
    always_comb begin
        cml_byte = status_cml;
        cml_byte[STBR_CML_IVC_BIT] = status_cml[STBR_CML_IVC_BIT] | s_q.ivc;
        word_out = status_word;
        word_out[STBR_STATUS_BYTE_CML_BIT] =
            status_word[STBR_STATUS_BYTE_CML_BIT] | s_q.ivc;
    end

    // Temperature has no disable input: it feeds overtemperature protection
    // and so is always live.
    always_comb begin
        telemetry_block = {
            STBR_SLOT_UNSUPPORTED,
            STBR_SLOT_UNSUPPORTED,
            vin_disabled ? STBR_SLOT_DISABLED : telemetry_vin,
            telemetry_temperature,
            iout_disabled ? STBR_SLOT_DISABLED : telemetry_iout,
            vout_disabled ? STBR_SLOT_DISABLED : telemetry_vout,
            word_out
        };
        status_block = {status_mfr, status_other, cml_byte, status_temperature,
                        status_input, status_iout, status_vout};
    end

    // Phases that are unassigned or disabled are masked out of every answer.
    assign phase_visible = s_q.phase_flags & phase_enabled;

    // A selector above the fitted phases reads as no fault, the same as a
    // phase that is not assigned.
    always_comb begin
        phase_word = 16'h0000;
        if (phase_select == STBR_PHASE_ALL) begin
            phase_word[NUM_PHASES-1:0] = phase_visible;
        end else if (phase_select < 8'(NUM_PHASES)) begin
            phase_word[0] = selected_phase_status_any
                & phase_enabled[phase_select[1:0]];
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Only reads of the three commands load the serializer; other command
    // codes belong to neighbouring logic and are left alone here.
    always_comb begin
        load = 1'b0;
        load_len = 4'h0;
        load_data = '0;
        if (cmd_valid && !cmd_write) begin
            case (cmd_code)
                STBR_CMD_TELEMETRY_BLOCK: begin
                    load = 1'b1;
                    load_len = STBR_TELEMETRY_BYTES + 4'h1;
                    load_data = {telemetry_block, 4'h0, STBR_TELEMETRY_BYTES};
                end
                STBR_CMD_STATUS_BLOCK: begin
                    load = 1'b1;
                    load_len = STBR_STATUS_BYTES + 4'h1;
                    load_data = {56'h0, status_block, 4'h0, STBR_STATUS_BYTES};
                end
                STBR_CMD_PHASE_SUMMARY: begin
                    load = 1'b1;
                    load_len = STBR_PHASE_BYTES;
                    load_data = {104'h0, phase_word};
                end
                default: begin
                    load = 1'b0;
                end
            endcase
        end
    end

    // Writes to either block command are refused; nothing is stored, so a
    // write to the status block cannot act as a clear.
    assign write_read_only = cmd_valid && cmd_write
        && (cmd_code == STBR_CMD_TELEMETRY_BLOCK || cmd_code == STBR_CMD_STATUS_BLOCK);
    assign write_phase = cmd_valid && cmd_write
        && (cmd_code == STBR_CMD_PHASE_SUMMARY);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Writing a one clears that phase flag; a fault arriving in the
        // same cycle still sets it, so no fault is lost to a clear.
        if (write_phase) begin
            s_d.phase_flags = s_q.phase_flags & ~cmd_wdata[NUM_PHASES-1:0];
        end
        s_d.phase_flags = s_d.phase_flags | phase_fault_event;
        if (cml_clear) begin
            s_d.ivc = 1'b0;
        end
        if (write_read_only) begin
            s_d.ivc = 1'b1;
        end
        s_d.alert_n = ~s_d.ivc;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q.ivc <= 1'b0;
            s_q.alert_n <= 1'b1;
            s_q.phase_flags <= STBR_PHASE_FLAGS_RESET[NUM_PHASES-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    assign cml_ivc_q = s_q.ivc;
    assign alert_n_q = s_q.alert_n;
    assign phase_fault_flags_q = s_q.phase_flags;

    // ------------------------------------------------------------
    // Byte stream out
    // ------------------------------------------------------------
    // The answer is captured at the command edge, so status that moves while
    // the host is still reading cannot tear one block apart.
    stbr_byte_serializer #(
        .MAX_BYTES(STBR_MAX_BYTES)
    ) u_serializer (
        .clock(clock),
        .srst(srst),
        .load(load),
        .load_len(load_len),
        .load_data(load_data),
        .next(rd_next),
        .valid_q(rd_valid_q),
        .byte_q(rd_byte_q),
        .last_q(rd_last_q)
    );

endmodule : stbr_top

`default_nettype wire

// [stbr_top_properties.sv]
// Checker for the command and byte stream ports of the status block read logic.
`timescale 1ns/10ps
`default_nettype none

module stbr_top_properties
    import stbr_pkg::*;
#(
    parameter int NUM_PHASES = 4
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic rd_next,
    input wire logic cml_clear,
    input wire logic [NUM_PHASES-1:0] phase_fault_event,
    input wire logic rd_valid_q,
    input wire logic [7:0] rd_byte_q,
    input wire logic rd_last_q,
    input wire logic cml_ivc_q,
    input wire logic alert_n_q,
    input wire logic [NUM_PHASES-1:0] phase_fault_flags_q
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    logic rd_go;
    logic ro_wr;
    logic dc_wr;
    assign rd_go = cmd_valid && !cmd_write;
    assign ro_wr = cmd_valid && cmd_write && cmd_code inside {8'hDA, 8'hDB};
    assign dc_wr = cmd_valid && cmd_write && cmd_code == STBR_CMD_PHASE_SUMMARY;

    a_telem_count: assert property (
        rd_go && cmd_code == STBR_CMD_TELEMETRY_BLOCK |=> rd_valid_q && rd_byte_q == 8'h0E)
        else $error("telemetry count byte wrong");
    a_status_count: assert property (
        rd_go && cmd_code == STBR_CMD_STATUS_BLOCK |=> rd_valid_q && rd_byte_q == 8'h07)
        else $error("status count byte wrong");
    a_phase_answer: assert property (
        rd_go && cmd_code == STBR_CMD_PHASE_SUMMARY |=> rd_valid_q && !rd_last_q)
        else $error("phase word not started");
    a_ivc_raise: assert property (ro_wr |=> cml_ivc_q && !alert_n_q)
        else $error("invalid command flag not raised");
    a_ivc_hold: assert property (cml_ivc_q && !cml_clear |=> cml_ivc_q)
        else $error("invalid command flag lost");
    a_alert_track: assert property (alert_n_q != cml_ivc_q)
        else $error("alert does not follow flag");
    a_flags_sticky: assert property (
        !dc_wr |=> (phase_fault_flags_q & $past(phase_fault_flags_q))
            == $past(phase_fault_flags_q))
        else $error("phase flag cleared");
    a_flag_set: assert property (
        |phase_fault_event |=> (phase_fault_flags_q & $past(phase_fault_event))
            == $past(phase_fault_event))
        else $error("phase flag not set");
    a_byte_stands: assert property (
        rd_valid_q && !rd_next && !cmd_valid |=> rd_valid_q && $stable(rd_byte_q))
        else $error("byte changed untaken");
    a_stream_end: assert property (
        rd_valid_q && rd_last_q && rd_next && !cmd_valid |=> !rd_valid_q)
        else $error("stream ran past last byte");
    c_ro_write: cover property (ro_wr);
    c_phase_read: cover property (rd_go && cmd_code == 8'hDC);
    c_stream_end: cover property (rd_valid_q && rd_last_q && rd_next);
endmodule : stbr_top_properties

bind stbr_top stbr_top_properties #(.NUM_PHASES(NUM_PHASES)) props_u (.clock(clock), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write), .rd_next(rd_next),
    .cml_clear(cml_clear), .phase_fault_event(phase_fault_event), .rd_valid_q(rd_valid_q),
    .rd_byte_q(rd_byte_q), .rd_last_q(rd_last_q), .cml_ivc_q(cml_ivc_q), .alert_n_q(alert_n_q),
    .phase_fault_flags_q(phase_fault_flags_q));
`default_nettype wire

// [stbr_host_model.sv]
// Host controller model that takes block read bytes, promptly or with random stalls.
`timescale 1ns/10ps
`default_nettype none

module stbr_host_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic slow,
    input wire logic rd_valid_q,
    input wire logic [7:0] rd_byte_q,
    input wire logic rd_last_q,
    output logic rd_next
);
    logic [8:0] rx_q[$];
    initial rd_next = 1'h0;
    // Bytes are kept in arrival order with their last flag above them.
    always @(posedge clock) begin
        if (!srst && rd_valid_q && rd_next) begin
            rx_q.push_back({rd_last_q, rd_byte_q});
        end
        rd_next <= slow ? ($urandom_range(0, 2) == 0) : 1'h1;
    end
endmodule : stbr_host_model
`default_nettype wire

// [stbr_top_tb.sv]
// Self-checking bench for the status block read logic.
`timescale 1ns/10ps
`default_nettype none

module stbr_top_tb;
    import stbr_pkg::*;
    logic clock, srst, cmd_valid, cmd_write, cml_clear, rd_next, slow, rd_valid_q, rd_last_q;
    logic vin_disabled, iout_disabled, vout_disabled, selected_phase_status_any;
    logic cml_ivc_q, alert_n_q;
    logic [7:0] cmd_code, rd_byte_q, phase_select, status_mfr, status_other, status_cml, b;
    logic [7:0] status_temperature, status_input, status_iout, status_vout;
    logic [15:0] cmd_wdata, status_word, telemetry_vin, telemetry_temperature, w;
    logic [15:0] telemetry_iout, telemetry_vout;
    logic [3:0] phase_enabled, phase_fault_event, phase_fault_flags_q, flg, ev;
    logic [127:0] r;
    logic [7:0] exp_q[$];
    int errors = 0;
    int num_checks = 0;
    int ivc = 0;

    stbr_top #(.NUM_PHASES(4)) dut_u (.clock, .srst, .cmd_valid, .cmd_code, .cmd_write,
        .cmd_wdata, .rd_next, .cml_clear, .status_word, .status_mfr, .status_other,
        .status_cml, .status_temperature, .status_input, .status_iout, .status_vout,
        .telemetry_vin, .telemetry_temperature, .telemetry_iout, .telemetry_vout,
        .vin_disabled, .iout_disabled, .vout_disabled, .phase_select, .phase_enabled,
        .phase_fault_event, .selected_phase_status_any, .rd_valid_q, .rd_byte_q, .rd_last_q,
        .cml_ivc_q, .alert_n_q, .phase_fault_flags_q);
    stbr_host_model host_u (.clock, .srst, .slow, .rd_valid_q, .rd_byte_q, .rd_last_q,
        .rd_next);

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task cmd(input logic [7:0] c, input logic wr, input logic [15:0] d);
        cmd_valid <= 1'h1;
        cmd_code <= c;
        cmd_write <= wr;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'h0;
    endtask : cmd

    task rnd;
        r = {$urandom, $urandom, $urandom, $urandom};
        {status_word, status_mfr, status_other, status_cml, status_temperature} <= r[47:0];
        {status_input, status_iout, status_vout} <= r[71:48];
        {telemetry_vin, telemetry_temperature, telemetry_iout, telemetry_vout} <= r[127:64];
        {phase_enabled, selected_phase_status_any} <= 5'($urandom);
        @(posedge clock);
    endtask : rnd

    task p16(input logic [15:0] v);
        exp_q.push_back(v[7:0]);
        exp_q.push_back(v[15:8]);
    endtask : p16

    task rd(input logic [7:0] c);
        int n;
        host_u.rx_q.delete();
        cmd(c, 1'h0, 16'h0000);
        for (n = 0; n < 200 && host_u.rx_q.size() < exp_q.size(); n++) @(posedge clock);
        repeat (2) @(posedge clock);
        chk(16'(rd_valid_q), 16'h0000);
        chk(16'(host_u.rx_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) begin
            chk(16'(host_u.rx_q[i]), 16'({i == exp_q.size() - 1, exp_q[i]}));
        end
        exp_q.delete();
    endtask : rd

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h3798));
        {cmd_valid, cmd_write, cml_clear, slow, vin_disabled, iout_disabled} <= 6'h00;
        {vout_disabled, selected_phase_status_any, cmd_code, phase_select} <= 18'h0_0000;
        {cmd_wdata, phase_enabled, phase_fault_event, status_word} <= 40'h00_0000_0000;
        {status_mfr, status_other, status_cml, status_temperature} <= 32'h0000_0000;
        {status_input, status_iout, status_vout} <= 24'h00_0000;
        {telemetry_vin, telemetry_temperature, telemetry_iout, telemetry_vout} <= '0;
        srst <= 1'h1;
        flg = 4'h0;
        repeat (20) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        chk(16'({alert_n_q, cml_ivc_q, rd_valid_q, phase_fault_flags_q}), 16'h0040);
        cmd(8'h55, 1'h0, 16'h0000);
        @(posedge clock);
        chk(16'(rd_valid_q), 16'h0000);
        cmd(STBR_CMD_TELEMETRY_BLOCK, 1'h1, 16'hFFFF);
        @(posedge clock);
        chk(16'({cml_ivc_q, alert_n_q}), 16'h0002);
        cml_clear <= 1'h1;
        cmd(STBR_CMD_STATUS_BLOCK, 1'h1, 16'h0000);
        cml_clear <= 1'h0;
        @(posedge clock);
        ivc = 1;
        chk(16'({cml_ivc_q, alert_n_q}), 16'h0002);
        $display("Invalid command writes done");
        for (int d = 0; d < 8; d++) begin
            if (d == 4) begin
                cml_clear <= 1'h1;
                @(posedge clock);
                cml_clear <= 1'h0;
                ivc = 0;
            end
            {vin_disabled, iout_disabled, vout_disabled} <= 3'(d);
            slow <= d[0];
            rnd();
            w = status_word | 16'(ivc << 1);
            exp_q = {8'h0E, w[7:0], w[15:8]};
            p16(vout_disabled ? 16'h0000 : telemetry_vout);
            p16(iout_disabled ? 16'h0000 : telemetry_iout);
            p16(telemetry_temperature);
            p16(vin_disabled ? 16'h0000 : telemetry_vin);
            p16(16'h0000);
            p16(16'h0000);
            rd(STBR_CMD_TELEMETRY_BLOCK);
            b = status_cml | 8'(ivc << 7);
            exp_q = {8'h07, status_vout, status_iout, status_input, status_temperature, b};
            exp_q = {exp_q, status_other, status_mfr};
            rd(STBR_CMD_STATUS_BLOCK);
        end
        $display("Block reads done");
        ev = 4'($urandom) | 4'h9;
        phase_fault_event <= ev;
        @(posedge clock);
        phase_fault_event <= 4'h0;
        flg = ev;
        @(posedge clock);
        chk(16'(phase_fault_flags_q), 16'(flg));
        for (int s = 0; s < 6; s++) begin
            phase_select <= (s == 5) ? STBR_PHASE_ALL : 8'(s);
            rnd();
            b = (s == 5) ? 8'(flg & phase_enabled)
                : 8'(s < 4 && phase_enabled[s % 4] && selected_phase_status_any);
            exp_q = {b, 8'h00};
            rd(STBR_CMD_PHASE_SUMMARY);
        end
        cmd(STBR_CMD_PHASE_SUMMARY, 1'h1, 16'h0005);
        flg = flg & 4'hA;
        @(posedge clock);
        chk(16'(phase_fault_flags_q), 16'(flg));
        phase_fault_event <= 4'h8;
        cmd(STBR_CMD_PHASE_SUMMARY, 1'h1, 16'h0008);
        phase_fault_event <= 4'h0;
        @(posedge clock);
        chk(16'(phase_fault_flags_q), 16'(flg | 4'h8));
        $display("Phase summary done");
        complete_run();
    end
endmodule : stbr_top_tb
`default_nettype wire
